// ==== src/djk_defs.svh ====
// Constants of the dual falling-edge J-K flip-flop block
//
// Operation
// - Two independent flip-flops, each clocked only on the falling edge of its own clock pin.
// - On a falling edge with both requests low and the forcing inputs high, both outputs hold.
// - On a falling edge with only the set request high, the true output goes high and the complement low.
// - On a falling edge with only the zero request high, the true output goes low and the complement high.
// - On a falling edge with both requests high, the stored state inverts and both outputs swap.
// - While the clock pin stays high, or does not fall, the outputs hold whatever the requests do.
// - With both forcing inputs low, both outputs go high, and this does not persist after either is released.
// - A low preset forces the true output high and a low zero input alone forces it low, whatever clock and requests do.
// - Clocked transfer happens only while both forcing inputs are high; outside logic releases them first.
`ifndef DJK_DEFS_SVH
`define DJK_DEFS_SVH

// ==========================================================
// Structure
`define DJK_NUM_FLOPS  2
`define DJK_PIN_BITS   5

// ==========================================================
// Reset values
`define DJK_Q_RST      1'h0
`define DJK_QN_RST     1'h1
`define DJK_CLK_RST    1'h0
// Clock low, requests low, forcing inputs inactive high
`define DJK_PIN_RST    5'h03

`endif

// ==== src/djk_pkg.sv ====
// Types shared by the dual falling-edge J-K flip-flop block
package djk_pkg;

  // Pins of one flip-flop, as seen after synchronisation
  typedef struct packed {
    logic clk;
    logic set_req;
    logic zero_req;
    logic async_one_n;
    logic async_zero_n;
  } djk_pins_t;

  // State of one flip-flop
  typedef struct packed {
    logic q;
    logic qn;
    logic clk_prev;
  } djk_flop_t;

  // State of both flip-flops
  typedef struct packed {
    djk_flop_t [1:0] flop;
  } djk_state_t;

endpackage

// ==== src/djk_sync.sv ====
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module djk_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } djk_sync_state_t;

  djk_sync_state_t state_reg;
  djk_sync_state_t state_next;

  // ==========================================================
  // Next state: first stage feeds only the second
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = pin_i;
    state_next.stable = state_reg.meta;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= {RST_VAL, RST_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule

// ==== src/djk_top.sv ====
// Dual J-K flip-flop, falling-edge clocked, with active-low preset and zero inputs
`timescale 1ns/1ps
`include "djk_defs.svh"
module djk_top (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] flop_clk_i,
  input  wire logic [1:0] set_req_i,
  input  wire logic [1:0] zero_req_i,
  input  wire logic [1:0] async_one_n_i,
  input  wire logic [1:0] async_zero_n_i,
  output logic      [1:0] q_o,
  output logic      [1:0] qn_o
);

  localparam int PW = `DJK_PIN_BITS;
  localparam int NF = `DJK_NUM_FLOPS;

  // ==========================================================
  // Pin gathering
  djk_pkg::djk_pins_t [1:0] pins_raw;
  djk_pkg::djk_pins_t [1:0] pins_sync;
  logic [NF*PW-1:0]         pins_raw_flat;
  logic [NF*PW-1:0]         pins_sync_flat;

  // Pack each flop's pins into one record
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      pins_raw[i].clk          = flop_clk_i[i];
      pins_raw[i].set_req      = set_req_i[i];
      pins_raw[i].zero_req     = zero_req_i[i];
      pins_raw[i].async_one_n  = async_one_n_i[i];
      pins_raw[i].async_zero_n = async_zero_n_i[i];
    end
  end

  assign pins_raw_flat = pins_raw;
  assign pins_sync     = pins_sync_flat;

  // ==========================================================
  // Synchronisers: every pin passes two flip-flops before use
  djk_sync #(
    .W       (NF*PW),
    .RST_VAL ({NF{`DJK_PIN_RST}})
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     (pins_raw_flat),
    .sync_o    (pins_sync_flat)
  );

  // ==========================================================
  // Flip-flop state
  djk_pkg::djk_state_t state_reg;
  djk_pkg::djk_state_t state_next;

  // Falling-edge detect per flop, from the stable stage only
  logic [1:0] fall_edge;

  always_comb begin
    for (int i = 0; i < NF; i++) begin
      // Each flop watches only its own clock pin
      fall_edge[i] = state_reg.flop[i].clk_prev & ~pins_sync[i].clk;
    end
  end

  // ==========================================================
  // Next-state logic for both flops
  // Forcing inputs outrank the clock; the clocked path runs only
  // when both are inactive, so a forcing pulse never races a
  // clock edge inside the same flop.
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NF; i++) begin
      state_next.flop[i].clk_prev = pins_sync[i].clk;
      if (!pins_sync[i].async_one_n && !pins_sync[i].async_zero_n) begin
        // Both forced: both outputs high, nothing stored beyond this
        state_next.flop[i].q  = 1'h1;
        state_next.flop[i].qn = 1'h1;
      end else if (!pins_sync[i].async_one_n) begin
        // Preset alone wins over clock and requests
        state_next.flop[i].q  = 1'h1;
        state_next.flop[i].qn = 1'h0;
      end else if (!pins_sync[i].async_zero_n) begin
        // Zero input alone wins over clock and requests
        state_next.flop[i].q  = 1'h0;
        state_next.flop[i].qn = 1'h1;
      end else if (fall_edge[i]) begin
        // Clocked transfer only with both forcing inputs high
        case ({pins_sync[i].set_req, pins_sync[i].zero_req})
          2'h0: begin
            state_next.flop[i].q  = state_reg.flop[i].q;
            state_next.flop[i].qn = ~state_reg.flop[i].q;
          end
          2'h2: begin
            state_next.flop[i].q  = 1'h1;
            state_next.flop[i].qn = 1'h0;
          end
          2'h1: begin
            state_next.flop[i].q  = 1'h0;
            state_next.flop[i].qn = 1'h1;
          end
          2'h3: begin
            state_next.flop[i].q  = ~state_reg.flop[i].q;
            state_next.flop[i].qn = state_reg.flop[i].q;
          end
          default: begin
            state_next.flop[i].q  = state_reg.flop[i].q;
            state_next.flop[i].qn = ~state_reg.flop[i].q;
          end
        endcase
      end else begin
        // No falling edge: hold, and drop a leftover both-high pair
        state_next.flop[i].q  = state_reg.flop[i].q;
        state_next.flop[i].qn = ~state_reg.flop[i].q;
      end
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NF; i++) begin
        state_reg.flop[i].q        <= `DJK_Q_RST;
        state_reg.flop[i].qn       <= `DJK_QN_RST;
        state_reg.flop[i].clk_prev <= `DJK_CLK_RST;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs straight from the state registers
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      q_o[i]  = state_reg.flop[i].q;
      qn_o[i] = state_reg.flop[i].qn;
    end
  end

endmodule

// ==== verif/djk_chk.sv ====
// Checker of the dual falling-edge flip-flop outputs
`timescale 1ns/1ps
module djk_chk (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic [1:0] flop_clk_i,
  input wire logic [1:0] set_req_i,
  input wire logic [1:0] zero_req_i,
  input wire logic [1:0] async_one_n_i,
  input wire logic [1:0] async_zero_n_i,
  input wire logic [1:0] q_o,
  input wire logic [1:0] qn_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Clocked transfer: a sampled fall of flop 0 clock, forcing released
  sequence fall0;
    !flop_clk_i[0] && $past(flop_clk_i[0]) && async_one_n_i[0] && async_zero_n_i[0];
  endsequence
  // Sampled fall of flop 1 clock, forcing released
  sequence fall1;
    !flop_clk_i[1] && $past(flop_clk_i[1]) && async_one_n_i[1] && async_zero_n_i[1];
  endsequence
  a_hold_idle: assert property (fall0 ##0 !set_req_i[0] && !zero_req_i[0] |-> ##3 $stable(q_o[0]))
    else $error("flop 0 changed on an idle fall");
  a_set_high: assert property (fall0 ##0 set_req_i[0] && !zero_req_i[0] |-> ##3 q_o[0] && !qn_o[0])
    else $error("flop 0 not set on fall");
  a_zero_low: assert property (fall0 ##0 !set_req_i[0] && zero_req_i[0] |-> ##3 !q_o[0] && qn_o[0])
    else $error("flop 0 not cleared on fall");
  a_toggle_swap: assert property (fall0 ##0 set_req_i[0] && zero_req_i[0] |-> ##3 q_o[0] != $past(q_o[0]))
    else $error("flop 0 did not toggle");
  a_high_hold: assert property (flop_clk_i[0] && async_one_n_i[0] && async_zero_n_i[0]
    |-> ##3 $stable(q_o[0]))
    else $error("flop 0 changed without a fall");
  a_flop1_set: assert property (fall1 ##0 set_req_i[1] && !zero_req_i[1] |-> ##3 q_o[1] && !qn_o[1])
    else $error("flop 1 not set on its own fall");
  // ==========================================================
  // Forcing inputs, three cycles through the synchronisers
  a_both_high: assert property (!async_one_n_i[0] && !async_zero_n_i[0] |-> ##3 q_o[0] && qn_o[0])
    else $error("both forced low but outputs not high");
  a_one_force: assert property (!async_one_n_i[0] && async_zero_n_i[0] |-> ##3 q_o[0] && !qn_o[0])
    else $error("preset did not force true high");
  a_zero_force: assert property (async_one_n_i[0] && !async_zero_n_i[0] |-> ##3 !q_o[0] && qn_o[0])
    else $error("clear did not force true low");
  a_comp_inv: assert property ((async_one_n_i[0] || async_zero_n_i[0]) [*5] |-> qn_o[0] == !q_o[0])
    else $error("complement output not inverse");
endmodule

bind djk_top djk_chk djk_chk_i (.sys_clk_i, .resetn_i, .flop_clk_i, .set_req_i, .zero_req_i,
  .async_one_n_i, .async_zero_n_i, .q_o, .qn_o);

// ==== verif/djk_drv.sv ====
// Model of the outside logic that drives the flip-flop pins
`timescale 1ns/1ps
module djk_drv (
  input  wire logic       sys_clk_i,
  output logic      [1:0] flop_clk_o,
  output logic      [1:0] set_o,
  output logic      [1:0] zero_o,
  output logic      [1:0] one_n_o,
  output logic      [1:0] zero_n_o
);
  // Idle: clocks low, requests low, forcing released
  initial {flop_clk_o, set_o, zero_o, one_n_o, zero_n_o} = 10'h00F;
  // ==========================================================
  // Pin levels change at the falling edge and settle before any fall
  task pins(input int i, input logic [3:0] v);
    @(negedge sys_clk_i);
    {set_o[i], zero_o[i], one_n_o[i], zero_n_o[i]} = v;
    repeat (4) @(negedge sys_clk_i);
  endtask
  // Clock level held long enough for the synchronisers
  task edge_to(input int i, input logic lv);
    @(negedge sys_clk_i);
    flop_clk_o[i] = lv;
    repeat (4) @(negedge sys_clk_i);
  endtask
endmodule

// ==== verif/tb_djk_top.sv ====
// Self-checking bench of the dual falling-edge flip-flop
`timescale 1ns/1ps
module tb_djk_top;
  logic       sys_clk  = 1'h0;
  logic       resetn   = 1'h0;
  logic [1:0] fclk;
  logic [1:0] setr;
  logic [1:0] zr;
  logic [1:0] on_n;
  logic [1:0] zn_n;
  logic [1:0] q;
  logic [1:0] qn;
  int         err_count = 0;
  int         n_tests   = 0;
  always #5 sys_clk = ~sys_clk;
  djk_drv djk_drv_i (.sys_clk_i(sys_clk), .flop_clk_o(fclk), .set_o(setr), .zero_o(zr), .one_n_o(on_n),
    .zero_n_o(zn_n));
  djk_top djk_top_i (.sys_clk_i(sys_clk), .resetn_i(resetn), .flop_clk_i(fclk), .set_req_i(setr),
    .zero_req_i(zr), .async_one_n_i(on_n), .async_zero_n_i(zn_n), .q_o(q), .qn_o(qn));
  // ==========================================================
  // Compare both output pairs
  task chk(input string nm, input logic [1:0] eq, input logic [1:0] eqn);
    n_tests++;
    if ({q, qn} !== {eq, eqn}) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, {eq, eqn}, {q, qn});
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Set, hold, clear, toggle twice on flop 0; flop 1 stays put
  task automatic t_clocked;
    logic [3:0] v [5] = '{4'hB, 4'h3, 4'h7, 4'hF, 4'hF};
    logic [4:0] e     = 5'h0B;
    for (int k = 0; k < 5; k++) begin
      djk_drv_i.pins(0, v[k]);
      djk_drv_i.edge_to(0, 1'h1);
      djk_drv_i.edge_to(0, 1'h0);
      chk("clocked", {1'h0, e[k]}, {1'h1, ~e[k]});
    end
  endtask
  // Requests change while clock high, then fall toggles
  task t_clk_high;
    djk_drv_i.pins(1, 4'hB);
    djk_drv_i.edge_to(1, 1'h1);
    djk_drv_i.edge_to(1, 1'h0);
    chk("flop1", 2'h2, 2'h1);
    djk_drv_i.edge_to(0, 1'h1);
    djk_drv_i.pins(0, 4'hB);
    djk_drv_i.pins(0, 4'hF);
    chk("clk_high", 2'h2, 2'h1);
    djk_drv_i.edge_to(0, 1'h0);
    chk("clk_fall", 2'h3, 2'h0);
  endtask
  // Forcing inputs and a fall ignored while clear is low
  task t_force;
    djk_drv_i.pins(0, 4'hE);
    chk("clear", 2'h2, 2'h1);
    djk_drv_i.edge_to(0, 1'h1);
    djk_drv_i.edge_to(0, 1'h0);
    chk("fall_forced", 2'h2, 2'h1);
    djk_drv_i.pins(0, 4'hD);
    chk("preset", 2'h3, 2'h0);
    djk_drv_i.pins(0, 4'hC);
    chk("both_low", 2'h3, 2'h1);
    djk_drv_i.pins(0, 4'hE);
    chk("release", 2'h2, 2'h1);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    resetn = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk("reset", 2'h0, 2'h3);
    t_clocked;
    t_clk_high;
    t_force;
    results;
  end
  // Watchdog
  initial begin
    #100000;
    err_count++;
    results;
  end
endmodule
